// >>> verilog/dft_pkg.sv
// Constants, register map and carrier types of the dynamic fan-start temperature loop.
// Assumes temperatures use the offset-64 code: code 0x00 is -64 degrees, 0xFF is 191 degrees.
package dft_pkg;

    // ------------------------------------------------------------------
    // Register offsets.
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL1    = 8'h0B;
    localparam logic [7:0] ADDR_CTRL2    = 8'h0C;
    localparam logic [7:0] ADDR_OP_ZONE1 = 8'h5A;
    localparam logic [7:0] ADDR_OP_ZONE2 = 8'h5B;
    localparam logic [7:0] ADDR_HYST     = 8'h64;

    // ------------------------------------------------------------------
    // Reset values.
    // ------------------------------------------------------------------
    localparam logic [7:0] CTRL1_RST = 8'h00;
    localparam logic [7:0] CTRL2_RST = 8'h00;
    localparam logic [7:0] OP_RST    = 8'hA4;
    localparam logic [7:0] HYST_RST  = 8'h40;

    // ------------------------------------------------------------------
    // Field positions.
    // ------------------------------------------------------------------
    localparam int CTRL1_EN_LSB   = 0;
    localparam int CTRL1_TRIP_LSB = 2;
    localparam int CYC_SEL_W      = 3;
    localparam int HYST_LSB       = 4;
    localparam int HYST_W         = 4;

    // ------------------------------------------------------------------
    // Loop constants.
    // ------------------------------------------------------------------
    localparam int          NUM_ZONES     = 2;
    localparam int          CNT_W         = 11;
    localparam logic [10:0] BASE_SHORT    = 11'h008;
    localparam logic [9:0]  SMALL_RISE_Q  = 10'h001;
    localparam logic [7:0]  TMIN_FLOOR    = 8'h00;
    localparam logic [7:0]  TMIN_CEIL     = 8'hFE;
    localparam logic [7:0]  LONG_STEP     = 8'h01;

    // ------------------------------------------------------------------
    // Per-zone measurement and limits, temperature in quarter degrees.
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [9:0] temp_q;
        logic [7:0] low_limit;
        logic [7:0] high_limit;
    } dft_zone_in_type;

endpackage : dft_pkg

// >>> verilog/dft_dyn_start_temp.sv
// Dynamic fan-start temperature adjustment for two remote temperature zones.
// Assumes monitor_tick pulses once per completed monitoring cycle and all inputs are synchronous to clk.
//
// Functional notes
// R1: Temperature within op-minus-hysteresis and low limit leaves start temperature unchanged.
// R2: Above op-minus-hysteresis, short cycle lowers start temperature by twice the rise.
// R3: Short cycle makes no reduction when rise is at most a quarter degree.
// R4: Long cycle makes no change between op-minus-hysteresis and op.
// R5: Above op, every long cycle lowers start temperature one more degree.
// R6: Below op, start temperature holds during quarter-degree slow rises.
// R7: Long cycle raises only below low, under high and op, above start temperature.
// R8: Adjusted start temperature never rises above the zone high limit.
// R9: Start temperature clamped at -64 degrees and kept below full scale.
// R10: Zone temperature below start temperature suspends adjustment for that zone.
// R11: Control one bit 1 enables adjustment for zone two.
// R12: Control one bit 0 enables adjustment for zone one.
// R13: Trip-copy bits copy remote temperature into op on a trip assertion.
// R14: The outside party asserts a trip by pulling the trip pin low.
// R15: Short cycle every n monitoring cycles, long every 2n, n from 8 to 1024.
// R16: Op is an eight-bit one-degree register with a four-bit hysteresis field.
// R17: Short reduction applies before the long step, results saturate, never wrap.
`timescale 1ns/1ps

module dft_dyn_start_temp #(
    parameter int NUM_ZONES = dft_pkg::NUM_ZONES
) (
    input  wire logic                     clk,
    input  wire logic                     reset,
    input  wire logic [7:0]               reg_addr,
    input  wire logic [7:0]               reg_wdata,
    input  wire logic                     reg_wr,
    output logic      [7:0]               reg_rdata,
    input  wire logic                     monitor_tick,
    input  wire dft_pkg::dft_zone_in_type zone_in [NUM_ZONES],
    input  wire logic [NUM_ZONES-1:0]     tmin_load,
    input  wire logic [7:0]               tmin_load_value [NUM_ZONES],
    input  wire logic                     thermal_trip_pin_in,
    output logic                          thermal_trip_pin_out,
    output logic                          thermal_trip_pin_oe,
    output logic      [7:0]               start_temp [NUM_ZONES]
);

    // ------------------------------------------------------------------
    // Elaboration check.
    // ------------------------------------------------------------------
    if (NUM_ZONES != dft_pkg::NUM_ZONES) begin : g_bad_zones
        $error("Register map serves exactly two zones.");
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    // ------------------------------------------------------------------
    // Register file.
    // ------------------------------------------------------------------
    logic [7:0] ctrl1_r, ctrl1_nxt;
    logic [7:0] ctrl2_r, ctrl2_nxt;
    logic [7:0] hyst_r, hyst_nxt;
    logic [7:0] op_r [NUM_ZONES];
    logic [7:0] op_nxt [NUM_ZONES];
    logic [7:0] rdata_r, rdata_nxt;
    logic       trip_prev_r, trip_prev_nxt;
    logic       trip_fall;
    logic [7:0] tmin_r [NUM_ZONES];

    always_comb begin
        ctrl1_nxt     = ctrl1_r;
        ctrl2_nxt     = ctrl2_r;
        hyst_nxt      = hyst_r;
        trip_prev_nxt = thermal_trip_pin_in;
        trip_fall     = trip_prev_r && !thermal_trip_pin_in; // [R14]
        for (int z = 0; z < NUM_ZONES; z++) begin
            op_nxt[z] = op_r[z];
        end
        if (reg_wr) begin
            unique case (reg_addr)
                dft_pkg::ADDR_CTRL1:    ctrl1_nxt = reg_wdata;
                dft_pkg::ADDR_CTRL2:    ctrl2_nxt = reg_wdata;
                dft_pkg::ADDR_HYST:     hyst_nxt  = reg_wdata; // [R16]
                dft_pkg::ADDR_OP_ZONE1: op_nxt[0] = reg_wdata; // [R16]
                dft_pkg::ADDR_OP_ZONE2: op_nxt[1] = reg_wdata;
                default:                ctrl1_nxt = ctrl1_r;
            endcase
        end
        for (int z = 0; z < NUM_ZONES; z++) begin
            if (trip_fall && ctrl1_r[dft_pkg::CTRL1_TRIP_LSB + z]) begin
                op_nxt[z] = zone_in[z].temp_q[9:2]; // [R13]
            end
        end
        unique case (reg_addr)
            dft_pkg::ADDR_CTRL1:    rdata_nxt = ctrl1_r;
            dft_pkg::ADDR_CTRL2:    rdata_nxt = ctrl2_r;
            dft_pkg::ADDR_HYST:     rdata_nxt = hyst_r;
            dft_pkg::ADDR_OP_ZONE1: rdata_nxt = op_r[0];
            dft_pkg::ADDR_OP_ZONE2: rdata_nxt = op_r[1];
            default:                rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl1_r     <= dft_pkg::CTRL1_RST;
            ctrl2_r     <= dft_pkg::CTRL2_RST;
            hyst_r      <= dft_pkg::HYST_RST;
            rdata_r     <= 8'h00;
            trip_prev_r <= 1'b1;
            for (int z = 0; z < NUM_ZONES; z++) begin
                op_r[z] <= dft_pkg::OP_RST;
            end
        end else begin
            ctrl1_r     <= ctrl1_nxt;
            ctrl2_r     <= ctrl2_nxt;
            hyst_r      <= hyst_nxt;
            rdata_r     <= rdata_nxt;
            trip_prev_r <= trip_prev_nxt;
            for (int z = 0; z < NUM_ZONES; z++) begin
                op_r[z] <= op_nxt[z];
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs.
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            thermal_trip_pin_out <= 1'b0;
            thermal_trip_pin_oe  <= 1'b0;
        end else begin
            thermal_trip_pin_out <= 1'b0;
            thermal_trip_pin_oe  <= 1'b0;
        end
    end

    assign reg_rdata  = rdata_r;
    assign start_temp = tmin_r;

    // ------------------------------------------------------------------
    // Register checks.
    // ------------------------------------------------------------------
    sequence s_ctrl1_write;
        reg_wr && (reg_addr == dft_pkg::ADDR_CTRL1);
    endsequence

    sequence s_op1_write;
        reg_wr && (reg_addr == dft_pkg::ADDR_OP_ZONE1) && !(trip_fall && ctrl1_r[dft_pkg::CTRL1_TRIP_LSB]);
    endsequence

    a_ctrl1_write: assert property (s_ctrl1_write |=> ctrl1_r == $past(reg_wdata)) // [R11] [R12]
        else $error("Control one write lost.");

    a_cycle_write: assert property (reg_wr && reg_addr == dft_pkg::ADDR_CTRL2 |=> ctrl2_r == $past(reg_wdata)) // [R15]
        else $error("Cycle select write lost.");

    a_hyst_write: assert property (reg_wr && reg_addr == dft_pkg::ADDR_HYST |=> hyst_r == $past(reg_wdata)) // [R16]
        else $error("Hysteresis write lost.");

    a_op_write: assert property (s_op1_write |=> op_r[0] == $past(reg_wdata)) // [R16]
        else $error("Target point write lost.");

    a_ctrl1_read: assert property (reg_addr == dft_pkg::ADDR_CTRL1 |=> reg_rdata == $past(ctrl1_r)) // [R12]
        else $error("Control one read wrong.");

    a_op_read: assert property (reg_addr == dft_pkg::ADDR_OP_ZONE1 |=> reg_rdata == $past(op_r[0])) // [R16]
        else $error("Target point read wrong.");

    // ------------------------------------------------------------------
    // Per-zone adjustment loop.
    // ------------------------------------------------------------------
    logic [dft_pkg::CNT_W-1:0] cnt_r [NUM_ZONES];
    logic [9:0]                prev_q_r [NUM_ZONES];
    logic                      short_ev [NUM_ZONES];
    logic                      long_ev [NUM_ZONES];
    logic                      active [NUM_ZONES];
    logic [9:0]                rise_q [NUM_ZONES];
    logic                      over_thr [NUM_ZONES];
    logic                      over_op [NUM_ZONES];
    logic                      raise_ok [NUM_ZONES];

    for (genvar z = 0; z < NUM_ZONES; z++) begin : g_zone
        logic [dft_pkg::CNT_W-1:0] cnt_nxt;
        logic [dft_pkg::CNT_W-1:0] n_cyc;
        logic [dft_pkg::CNT_W-1:0] last_cnt;
        logic [2:0]                sel;
        logic [9:0]                prev_nxt;
        logic [9:0]                thr_q;
        logic [8:0]                step;
        logic [7:0]                t1;
        logic [7:0]                tmin_nxt;
        logic [7:0]                hyst;

        always_comb begin
            sel      = ctrl2_r[z*dft_pkg::CYC_SEL_W +: dft_pkg::CYC_SEL_W];
            n_cyc    = dft_pkg::BASE_SHORT << sel; // [R15]
            last_cnt = (n_cyc << 1) - 11'h001;
            short_ev[z] = monitor_tick && ((cnt_r[z] == n_cyc - 11'h001) || (cnt_r[z] >= last_cnt));
            long_ev[z]  = monitor_tick && (cnt_r[z] >= last_cnt); // [R15]
            cnt_nxt  = cnt_r[z];
            if (monitor_tick) begin
                cnt_nxt = (cnt_r[z] >= last_cnt) ? 11'h000 : cnt_r[z] + 11'h001;
            end
            prev_nxt = monitor_tick ? zone_in[z].temp_q : prev_q_r[z];
            rise_q[z] = (zone_in[z].temp_q > prev_q_r[z]) ? zone_in[z].temp_q - prev_q_r[z] : 10'h000;
            hyst     = {4'h0, hyst_r[dft_pkg::HYST_LSB +: dft_pkg::HYST_W]};
            thr_q    = (op_r[z] >= hyst) ? {op_r[z] - hyst, 2'b00} : 10'h000;
            over_thr[z] = zone_in[z].temp_q > thr_q;
            over_op[z]  = zone_in[z].temp_q > {op_r[z], 2'b00};
            // Disabled zones and zones below the start temperature are left alone.
            active[z] = ctrl1_r[dft_pkg::CTRL1_EN_LSB + z] && (zone_in[z].temp_q >= {tmin_r[z], 2'b00}); // [R10] [R11] [R12]
            raise_ok[z] = (zone_in[z].temp_q < {zone_in[z].low_limit, 2'b00})
                       && (tmin_r[z] < zone_in[z].high_limit) && (tmin_r[z] < op_r[z])
                       && (zone_in[z].temp_q > {tmin_r[z], 2'b00}) && (tmin_r[z] < dft_pkg::TMIN_CEIL); // [R7] [R8] [R9]
            step = 9'h000;
            if (short_ev[z] && active[z] && over_thr[z] && (rise_q[z] > dft_pkg::SMALL_RISE_Q)) begin // [R2] [R3] [R6]
                step = rise_q[z][9:1]; // [R2]
            end
            t1 = ({1'b0, tmin_r[z]} > step) ? tmin_r[z] - step[7:0] : dft_pkg::TMIN_FLOOR; // [R9] [R17]
            if (long_ev[z] && active[z]) begin
                if (over_op[z]) begin
                    t1 = (t1 > dft_pkg::TMIN_FLOOR) ? t1 - dft_pkg::LONG_STEP : dft_pkg::TMIN_FLOOR; // [R5] [R17]
                end else if (raise_ok[z] && (t1 == tmin_r[z])) begin
                    t1 = tmin_r[z] + dft_pkg::LONG_STEP; // [R7] [R4]
                end
            end
            tmin_nxt = tmin_load[z] ? tmin_load_value[z] : t1;
        end

        always_ff @(posedge clk) begin
            if (reset) begin
                cnt_r[z]    <= 11'h000;
                prev_q_r[z] <= 10'h000;
                tmin_r[z]   <= dft_pkg::TMIN_FLOOR;
            end else begin
                cnt_r[z]    <= cnt_nxt;
                prev_q_r[z] <= prev_nxt;
                tmin_r[z]   <= tmin_nxt;
            end
        end

        // ------------------------------------------------------------------
        // Checks.
        // ------------------------------------------------------------------
        sequence s_no_load;
            !tmin_load[z];
        endsequence

        sequence s_raise_ev;
            long_ev[z] && active[z] && raise_ok[z] && !over_op[z]
            && rise_q[z] <= dft_pkg::SMALL_RISE_Q && !tmin_load[z];
        endsequence

        a_hold_in_zone: assert property (monitor_tick && !over_thr[z] && !raise_ok[z] && !tmin_load[z] // [R1]
            |=> tmin_r[z] == $past(tmin_r[z])) else $error("Start temperature moved inside zone.");

        a_small_rise_hold: assert property (short_ev[z] && !over_op[z] && !raise_ok[z] // [R3] [R6]
            && rise_q[z] <= dft_pkg::SMALL_RISE_Q && !tmin_load[z]
            |=> tmin_r[z] == $past(tmin_r[z])) else $error("Small rise changed start temperature.");

        a_short_drop: assert property (short_ev[z] && !long_ev[z] && active[z] && over_thr[z] // [R2]
            && rise_q[z] == 10'h008 && tmin_r[z] >= 8'h04 && !tmin_load[z]
            |=> tmin_r[z] == $past(tmin_r[z]) - 8'h04) else $error("Short cycle drop wrong.");

        a_long_drop: assert property (long_ev[z] && active[z] && over_op[z] // [R5]
            && rise_q[z] <= dft_pkg::SMALL_RISE_Q && tmin_r[z] != 8'h00 && !tmin_load[z]
            |=> tmin_r[z] == $past(tmin_r[z]) - 8'h01) else $error("Long cycle drop missing.");

        a_mid_long_hold: assert property (long_ev[z] && over_thr[z] && !over_op[z] && !raise_ok[z] // [R4]
            && rise_q[z] <= dft_pkg::SMALL_RISE_Q && !tmin_load[z]
            |=> tmin_r[z] == $past(tmin_r[z])) else $error("Long cycle moved start temperature in band.");

        a_raise_step: assert property (s_raise_ev |=> tmin_r[z] == $past(tmin_r[z]) + 8'h01) // [R7]
            else $error("Long cycle raise missing.");

        a_raise_cause: assert property (s_no_load ##1 tmin_r[z] > $past(tmin_r[z]) // [R7] [R10]
            |-> $past(long_ev[z] && active[z] && raise_ok[z])) else $error("Raise without cause.");

        a_disabled_hold: assert property (!ctrl1_r[z] && !tmin_load[z] // [R11] [R12]
            |=> tmin_r[z] == $past(tmin_r[z])) else $error("Disabled zone adjusted.");

        a_below_start: assert property (zone_in[z].temp_q < {tmin_r[z], 2'b00} && !tmin_load[z] // [R10]
            |=> tmin_r[z] == $past(tmin_r[z])) else $error("Adjusted below start temperature.");

        a_rise_bounded: assert property (s_no_load ##1 tmin_r[z] > $past(tmin_r[z]) // [R8]
            |-> tmin_r[z] <= $past(zone_in[z].high_limit) && tmin_r[z] != 8'hFF) else $error("Rise past limit.");

        a_floor_hold: assert property (long_ev[z] && active[z] && over_op[z] && tmin_r[z] == 8'h00 // [R9] [R17]
            && !tmin_load[z] |=> tmin_r[z] == 8'h00) else $error("Start temperature floor wrapped.");

        a_ceiling_kept: assert property (!tmin_load[z] && tmin_r[z] != 8'hFF |=> tmin_r[z] != 8'hFF) // [R9]
            else $error("Start temperature reached full scale.");

        a_off_tick_hold: assert property (!monitor_tick && !tmin_load[z] |=> tmin_r[z] == $past(tmin_r[z])) // [R15]
            else $error("Start temperature moved between ticks.");

        a_count_hold: assert property (!monitor_tick |=> cnt_r[z] == $past(cnt_r[z])) // [R15]
            else $error("Cycle counter moved between ticks.");

        a_count_wrap: assert property (monitor_tick && cnt_r[z] >= last_cnt |=> cnt_r[z] == 11'h000) // [R15]
            else $error("Cycle counter did not wrap.");

        a_trip_copy: assert property (trip_fall && ctrl1_r[dft_pkg::CTRL1_TRIP_LSB + z] // [R13]
            |=> op_r[z] == $past(zone_in[z].temp_q[9:2])) else $error("Trip copy missing.");

        a_trip_ignore: assert property (trip_fall && !ctrl1_r[dft_pkg::CTRL1_TRIP_LSB + z] && !reg_wr // [R13]
            |=> op_r[z] == $past(op_r[z])) else $error("Trip not ignored.");
    end

endmodule : dft_dyn_start_temp

// >>> tb/dft_trip_source.sv
// Model of the processor thermal-throttle output that shares the trip pin.
// Assumes the trip wire carries a pull-up and every party only pulls it low.
`timescale 1ns/1ps

module dft_trip_source (
    input  wire logic pull_low,
    input  wire logic drv_out,
    input  wire logic drv_oe,
    output logic      pin_level
);
    // ------------------------------------------------------------------
    // Wire resolution: a pulled-low party wins, otherwise the pull-up.
    // ------------------------------------------------------------------
    assign pin_level = (pull_low || (drv_oe && !drv_out)) ? 1'b0 : 1'b1;
endmodule : dft_trip_source

// >>> tb/tb_dynamic_fan_start_temp_adjust.sv
// Self-checking bench of the dynamic fan-start temperature loop.
// Assumes the design and package from verilog/ and the trip pin model from tb/.
`timescale 1ns/1ps

module tb_dynamic_fan_start_temp_adjust;
    logic                     clk;
    logic                     reset;
    logic [7:0]               reg_addr;
    logic [7:0]               reg_wdata;
    logic                     reg_wr;
    logic [7:0]               reg_rdata;
    logic                     monitor_tick;
    dft_pkg::dft_zone_in_type zone_in [2];
    logic [1:0]               tmin_load;
    logic [7:0]               tmin_load_value [2];
    logic                     pull_low;
    logic                     pin_level;
    logic                     pin_out;
    logic                     pin_oe;
    logic [7:0]               start_temp [2];
    int                       errors;
    int                       comparisons;

    dft_dyn_start_temp dut (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rdata(reg_rdata), .monitor_tick(monitor_tick), .zone_in(zone_in),
        .tmin_load(tmin_load), .tmin_load_value(tmin_load_value), .thermal_trip_pin_in(pin_level),
        .thermal_trip_pin_out(pin_out), .thermal_trip_pin_oe(pin_oe), .start_temp(start_temp));

    dft_trip_source trip_src (.pull_low(pull_low), .drv_out(pin_out), .drv_oe(pin_oe), .pin_level(pin_level));

    // ------------------------------------------------------------------
    // Shared tasks.
    // ------------------------------------------------------------------
    task automatic wrap_up;
        if (errors == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) begin reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1; end
        @(posedge clk) reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk) reg_addr <= a;
        @(posedge clk);
        @(negedge clk) chk("register", reg_rdata, exp);
    endtask : rd

    task automatic set_z(input int z, input logic [9:0] t, input logic [7:0] lo, input logic [7:0] hi);
        @(posedge clk) zone_in[z] <= '{temp_q: t, low_limit: lo, high_limit: hi};
    endtask : set_z

    task automatic ticks(input int k);
        repeat (k) begin
            @(posedge clk) monitor_tick <= 1'b1;
            @(posedge clk) monitor_tick <= 1'b0;
        end
        @(negedge clk);
    endtask : ticks

    task automatic load(input logic [1:0] which, input logic [7:0] v);
        @(posedge clk) begin tmin_load <= which; tmin_load_value[0] <= v; tmin_load_value[1] <= v; end
        @(posedge clk) tmin_load <= 2'b00;
    endtask : load

    task automatic trip;
        @(posedge clk) pull_low <= 1'b1;
        repeat (3) @(posedge clk);
        pull_low <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : trip

    // ------------------------------------------------------------------
    // Clock, watchdog and main sequence.
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        wrap_up();
    end

    initial begin
        errors = 0; comparisons = 0; reset = 1'b1; reg_addr = 8'h00; reg_wdata = 8'h00; reg_wr = 1'b0;
        monitor_tick = 1'b0; tmin_load = 2'b00; tmin_load_value[0] = 8'h00; tmin_load_value[1] = 8'h00;
        pull_low = 1'b0;
        zone_in[0] = '{temp_q: 10'h280, low_limit: 8'h00, high_limit: 8'hFF};
        zone_in[1] = '{temp_q: 10'h280, low_limit: 8'h00, high_limit: 8'hFF};
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(negedge clk) chk("start zone1", start_temp[0], 8'h00);
        rd(8'h0B, 8'h00);
        rd(8'h0C, 8'h00);
        rd(8'h5A, 8'hA4);
        rd(8'h5B, 8'hA4);
        rd(8'h64, 8'h40);
        rd(8'h33, 8'h00);
        load(2'b11, 8'h80);
        wr(8'h0B, 8'h01);
        ticks(7);
        chk("start zone1", start_temp[0], 8'h80);
        set_z(0, 10'h288, 8'h00, 8'hFF);
        set_z(1, 10'h288, 8'h00, 8'hFF);
        ticks(1);
        chk("start zone1", start_temp[0], 8'h7C);
        chk("start zone2", start_temp[1], 8'h80);
        set_z(0, 10'h290, 8'h00, 8'hFF);
        ticks(7);
        chk("start zone1", start_temp[0], 8'h7C);
        set_z(0, 10'h291, 8'h00, 8'hFF);
        ticks(1);
        chk("start zone1", start_temp[0], 8'h7B);
        set_z(0, 10'h28C, 8'h00, 8'hFF);
        ticks(16);
        chk("start zone1", start_temp[0], 8'h7B);
        set_z(0, 10'h27C, 8'hA0, 8'hFF);
        ticks(16);
        chk("start zone1", start_temp[0], 8'h7C);
        set_z(0, 10'h27C, 8'hA0, 8'h7C);
        ticks(16);
        chk("start zone1", start_temp[0], 8'h7C);
        set_z(0, 10'h100, 8'hA0, 8'hFF);
        ticks(16);
        chk("start zone1", start_temp[0], 8'h7C);
        load(2'b01, 8'h01);
        set_z(0, 10'h3B0, 8'h00, 8'hFF);
        ticks(15);
        set_z(0, 10'h3F0, 8'h00, 8'hFF);
        ticks(1);
        chk("start zone1", start_temp[0], 8'h00);
        wr(8'h0B, 8'h04);
        trip();
        rd(8'h5A, 8'hFC);
        wr(8'h0B, 8'h08);
        set_z(1, 10'h200, 8'h00, 8'hFF);
        trip();
        rd(8'h5B, 8'h80);
        wr(8'h0B, 8'h00);
        set_z(0, 10'h2A8, 8'h00, 8'hFF);
        trip();
        rd(8'h5A, 8'hFC);
        chk("trip pin enable", {7'h00, pin_oe}, 8'h00);
        wrap_up();
    end
endmodule : tb_dynamic_fan_start_temp_adjust
